// ==== hw/timer16_cfg.svh ====
// Offsets, reset values and fixed counts of the 16-bit compare timer.
// Assumes byte addresses on a 32-bit Avalon-MM slave; data in bits 7:0.
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// Register byte offsets
`define OFS_CTRL        6'h00
`define OFS_IRQ_EN      6'h04
`define OFS_FLAGS       6'h08
`define OFS_FORCE       6'h0C
`define OFS_COUNT_LOW   6'h10
`define OFS_COUNT_HIGH  6'h14
`define OFS_CMPA_LOW    6'h18
`define OFS_CMPA_HIGH   6'h1C
`define OFS_CMPB_LOW    6'h20
`define OFS_CMPB_HIGH   6'h24
`define OFS_CAP_LOW     6'h28
`define OFS_CAP_HIGH    6'h2C

// Control field positions
`define CTRL_MODE_LSB   0
`define CTRL_ACTA_LSB   4
`define CTRL_ACTB_LSB   6

// Flag and enable bit positions
`define BIT_CMPA        0
`define BIT_CMPB        1
`define BIT_OVF         2

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

// Counter extremes and fixed tops
`define CNT_MAX         16'hFFFF
`define CNT_BOTTOM      16'h0000
`define TOP_8BIT        16'h00FF
`define TOP_9BIT        16'h01FF
`define TOP_10BIT       16'h03FF

`endif

// ==== hw/timer16_pkg.sv ====
// Types shared by the compare timer and its compare channel.
// Assumes timer16_cfg.svh holds offsets, bit positions and fixed values; this package holds shapes only.
package timer16_pkg;

    typedef logic [3:0] mode_t;     // Waveform mode selector
    typedef logic [1:0] action_t;   // Output action selector

    // State of one compare channel
    typedef struct packed {
        logic [15:0] compare;       // Working compare value
        logic [15:0] buffer;        // Double-buffer value
        logic        oc;            // Internal compare output
    } chan_s;

    // State of the top block
    typedef struct packed {
        logic        wait_r;        // Avalon waitrequest
        logic [7:0]  rdata;         // Avalon read byte
        logic [7:0]  temp;          // Shared high-byte latch
        logic [15:0] count;         // Timer count
        logic        dir_up;        // Dual-slope direction
        logic        block;         // Match blocking after count write
        mode_t       mode;          // Waveform mode
        action_t     act_a;         // Channel A action
        action_t     act_b;         // Channel B action
        logic [2:0]  ien;           // Interrupt enables
        logic [2:0]  flags;         // Match A, match B, overflow
        logic [15:0] cap;           // Capture value used as top
        logic [2:0]  irq;           // Interrupt requests
        logic [1:0]  pin_out;       // Pin drive values
        logic [1:0]  pin_oe;        // Pin drive enables
    } top_s;

endpackage

// ==== hw/compare_chan.sv ====
// One compare channel: buffer, working compare value and output register.
// Assumes the parent qualifies match and load events with the timer tick, and force with the mode.
`timescale 1ns/1ps
module compare_chan (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Value write and buffering control
    input  wire logic                 wr_en,
    input  wire logic [15:0]          wr_val,
    input  wire logic                 buffered,
    input  wire logic                 load_ev,
    // Output events and mode
    input  wire logic                 match_ev,
    input  wire logic                 force_ev,
    input  wire logic                 restart_ev,
    input  wire logic                 pwm,
    input  wire logic                 dual,
    input  wire logic                 dir_up,
    input  wire timer16_pkg::action_t action,
    // State seen by the parent
    output logic [15:0]               compare,
    output logic [15:0]               buffer,
    output logic                      oc
);
    timer16_pkg::chan_s q, d;       // Registered state and its next value

    // Next state: value path, then output register
    always_comb begin
        d = q;
        if (wr_en) begin
            d.buffer = wr_val;
            if (!buffered) begin
                d.compare = wr_val;
            end
        end
        if (buffered && load_ev) begin
            d.compare = q.buffer;
        end
        // Action 0 never touches the output, whatever the mode
        if (!pwm) begin
            if (match_ev || force_ev) begin
                unique case (action)
                    2'h1: d.oc = ~q.oc;
                    2'h2: d.oc = 1'b0;
                    2'h3: d.oc = 1'b1;
                    2'h0: d.oc = q.oc;
                endcase
            end
        end else if (action[1]) begin
            if (match_ev) begin
                d.oc = (dual && !dir_up) ? ~action[0] : action[0];
            end else if (restart_ev && !dual) begin
                d.oc = ~action[0];
            end
        end
    end

    // State register; reset clears the output register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign compare = q.compare;
    assign buffer  = q.buffer;
    assign oc      = q.oc;

    // Buffered value stays put between load points
    property p_buf_hold;
        @(posedge clk) disable iff (rst)
        buffered && !load_ev && !wr_en |=> $stable(compare);
    endproperty
    a_buf_hold: assert property (p_buf_hold)
        else $error("compare value changed outside a load point");

    // Action zero leaves the output alone
    property p_no_action;
        @(posedge clk) disable iff (rst)
        action == 2'h0 |=> $stable(oc);
    endproperty
    a_no_action: assert property (p_no_action)
        else $error("output changed with action zero");
endmodule

// ==== hw/timer16_output_compare.sv ====
// Two-channel 16-bit compare timer with overflow flag and pin override.
// Assumes an Avalon-MM master on clk, a one-cycle timer_tick from the
// prescaler and port register bits on the same clock.
//
// Contract
// - Compare on every timer tick; flag follows the match tick.
// - Enabled flag requests interrupt; ack or W1C clears.
// - Channel A value may serve as counter top.
// - PWM modes buffer compare; Normal/clear-on-match bypass.
// - Buffered value loads only at top or bottom.
// - CPU writes buffer or working value by mode.
// - Compare high byte read directly, not latched.
// - High byte latches; low write updates sixteen bits.
// - Force updates output only, no flag, no clear.
// - Count write blocks matches on next tick.
// - Output register keeps value across mode change.
// - Action field unbuffered, used at next match.
// - Reset clears each output register.
// - Nonzero action overrides port value; direction kept.
// - Action zero leaves output unchanged on match.
// - Action affects output only, never the count.
// - Mode zero counts up, wraps to zero.
// - Overflow flag set on wrap; ack or W1C clears.
// - Normal mode accepts count writes any time.
// - Action selects set/clear/toggle or PWM polarity.
// - Count write beats hardware clear or count.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_output_compare (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Prescaled timer clock enable
    input  wire logic        timer_tick,
    // Interrupt requests and service acknowledges
    output logic      [2:0]  irq_req,
    input  wire logic [2:0]  irq_ack,
    // Port logic for pins A and B
    input  wire logic [1:0]  port_out_value,
    input  wire logic [1:0]  pin_direction_bit,
    output logic      [1:0]  pin_out,
    output logic      [1:0]  pin_oe
);
    timer16_pkg::top_s q, d;        // Registered state and its next value

    // Channel state
    logic [15:0] cmp_a, cmp_b;      // Working compare values
    logic [15:0] buf_a, buf_b;      // Buffer values
    logic        oc_a, oc_b;        // Internal compare outputs

    // Decoded mode and events
    logic        pwm, dual, clear_on_match_mode;    // Mode classes
    logic        buffered;          // Double buffering active
    logic [15:0] top_v;             // Current top value
    logic        at_top, at_bot;    // Count at extremes
    logic        tick_run;          // Tick not overridden by a count write
    logic        load_ev;           // Buffer to compare transfer
    logic        match_a, match_b;  // Qualified compare matches
    logic        force_a, force_b;  // Force strobes
    logic        ovf_ev;            // Overflow event
    logic        done;              // Access completes this edge
    logic        wr_ok;             // Write completes, low lane enabled
    logic [7:0]  wbyte;             // Written byte
    logic        wr_cmpa, wr_cmpb;  // Low-byte compare writes
    logic        wr_cnt;            // Low-byte count write

    // Top value chosen by mode; A or capture may define it
    function automatic logic [15:0] top_of(input timer16_pkg::mode_t m,
                                           input logic [15:0] a,
                                           input logic [15:0] c);
        unique case (m)
            4'h1, 4'h5:               top_of = `TOP_8BIT;
            4'h2, 4'h6:               top_of = `TOP_9BIT;
            4'h3, 4'h7:               top_of = `TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF:   top_of = a;
            4'h8, 4'hA, 4'hC, 4'hE:   top_of = c;
            4'h0, 4'hD:               top_of = `CNT_MAX;
        endcase
    endfunction

    // Reading a compare value: buffer while buffered, else working value
    function automatic logic [15:0] cmp_view(input logic b,
                                             input logic [15:0] bv,
                                             input logic [15:0] wv);
        cmp_view = b ? bv : wv;
    endfunction

    // Mode classes; action fields take no part here
    always_comb begin
        clear_on_match_mode      = (q.mode == 4'h4) || (q.mode == 4'hC);
        pwm      = !(q.mode == 4'h0 || clear_on_match_mode || q.mode == 4'hD);
        dual     = (q.mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
        buffered = pwm;
        top_v    = top_of(q.mode, cmp_a, q.cap);
        at_top   = (q.count == top_v);
        at_bot   = (q.count == `CNT_BOTTOM);
    end

    // Bus decode; a request completes on the edge where waitrequest is low
    always_comb begin
        done    = (avs_read || avs_write) && !q.wait_r;
        wr_ok   = done && avs_write && avs_byteenable[0];
        wbyte   = avs_writedata[7:0];
        wr_cmpa = wr_ok && (avs_address == `OFS_CMPA_LOW);
        wr_cmpb = wr_ok && (avs_address == `OFS_CMPB_LOW);
        wr_cnt  = wr_ok && (avs_address == `OFS_COUNT_LOW);
        force_a = wr_ok && (avs_address == `OFS_FORCE) && wbyte[0] && !pwm;
        force_b = wr_ok && (avs_address == `OFS_FORCE) && wbyte[1] && !pwm;
    end

    // Timer events; a count write overrides this tick for overflow and load, not for matches
    always_comb begin
        tick_run = timer_tick && !wr_cnt;
        // Matches on a tick, unless a count write blocked this one
        match_a  = timer_tick && !q.block && (q.count == cmp_a);
        match_b  = timer_tick && !q.block && (q.count == cmp_b);
        if (dual) begin
            ovf_ev  = tick_run && at_bot && !q.dir_up;
            load_ev = tick_run && ((q.mode inside {4'h8, 4'h9}) ? at_bot : at_top);
        end else begin
            ovf_ev  = tick_run && (clear_on_match_mode ? (q.count == `CNT_MAX) : at_top);
            load_ev = tick_run && at_top;
        end
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        // Waitrequest drops for one cycle per request
        d.wait_r = !((avs_read || avs_write) && q.wait_r);
        if ((avs_read || avs_write) && q.wait_r) begin
            unique case (avs_address)
                `OFS_CTRL:       d.rdata = {q.act_b, q.act_a, q.mode};
                `OFS_IRQ_EN:     d.rdata = {5'h00, q.ien};
                `OFS_FLAGS:      d.rdata = {5'h00, q.flags};
                `OFS_COUNT_LOW:  d.rdata = q.count[7:0];
                `OFS_COUNT_HIGH: d.rdata = q.temp;
                `OFS_CMPA_LOW:   d.rdata = 8'(cmp_view(buffered, buf_a, cmp_a));
                // Compare high bytes never change by hardware, so no latch
                `OFS_CMPA_HIGH:  d.rdata = 8'(cmp_view(buffered, buf_a, cmp_a) >> 8);
                `OFS_CMPB_LOW:   d.rdata = 8'(cmp_view(buffered, buf_b, cmp_b));
                `OFS_CMPB_HIGH:  d.rdata = 8'(cmp_view(buffered, buf_b, cmp_b) >> 8);
                `OFS_CAP_LOW:    d.rdata = q.cap[7:0];
                `OFS_CAP_HIGH:   d.rdata = q.cap[15:8];
                default:         d.rdata = 8'h00;              // Unmapped reads zero
            endcase
        end
        // Count low read latches its high byte for the next high read
        if (done && avs_read && avs_address == `OFS_COUNT_LOW) begin
            d.temp = q.count[15:8];
        end
        // Register writes; high bytes only load the latch
        if (wr_ok) begin
            unique case (avs_address)
                `OFS_CTRL: begin
                    d.mode  = wbyte[3:0];
                    d.act_a = wbyte[5:4];
                    d.act_b = wbyte[7:6];
                end
                `OFS_IRQ_EN:     d.ien = wbyte[2:0];
                `OFS_COUNT_HIGH,
                `OFS_CMPA_HIGH,
                `OFS_CMPB_HIGH,
                `OFS_CAP_HIGH:   d.temp = wbyte;
                `OFS_CAP_LOW:    d.cap = {q.temp, wbyte};
                default:         d.temp = d.temp;
            endcase
        end
        // Counting; a count write wins over any count or clear
        if (wr_cnt) begin
            d.count = {q.temp, wbyte};
        end else if (tick_run) begin
            if (dual) begin
                if (q.dir_up) begin
                    d.dir_up = !at_top;
                    d.count  = at_top ? q.count - 16'h0001 : q.count + 16'h0001;
                end else begin
                    d.dir_up = at_bot;
                    d.count  = at_bot ? q.count + 16'h0001 : q.count - 16'h0001;
                end
            end else begin
                // Mode zero: top is MAX, so this is a plain wrap
                d.count  = at_top ? `CNT_BOTTOM : q.count + 16'h0001;
                d.dir_up = 1'b1;
            end
        end
        // Blocking lasts until the next tick after a count write
        if (wr_cnt) begin
            d.block = 1'b1;
        end else if (timer_tick) begin
            d.block = 1'b0;
        end
        // Flags: clears first, hardware sets last so a set wins
        if (wr_ok && avs_address == `OFS_FLAGS) begin
            d.flags = q.flags & ~wbyte[2:0];
        end
        d.flags = d.flags & ~irq_ack;
        if (match_a) begin
            d.flags[`BIT_CMPA] = 1'b1;
        end
        if (match_b) begin
            d.flags[`BIT_CMPB] = 1'b1;
        end
        if (ovf_ev) begin
            d.flags[`BIT_OVF] = 1'b1;
        end
        d.irq = d.flags & d.ien;
        // Pin override by nonzero action; direction always from the port
        d.pin_out[0] = (q.act_a != 2'h0) ? oc_a : port_out_value[0];
        d.pin_out[1] = (q.act_b != 2'h0) ? oc_b : port_out_value[1];
        d.pin_oe     = pin_direction_bit;
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q        <= '0;
            q.wait_r <= 1'b1;
            q.dir_up <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Channel A; its value may also set the top
    compare_chan u_chan_a (
        .clk        (clk),
        .rst        (rst),
        .wr_en      (wr_cmpa),
        .wr_val     ({q.temp, wbyte}),
        .buffered   (buffered),
        .load_ev    (load_ev),
        .match_ev   (match_a),
        .force_ev   (force_a),
        .restart_ev (load_ev),
        .pwm        (pwm),
        .dual       (dual),
        .dir_up     (q.dir_up),
        .action     (q.act_a),
        .compare    (cmp_a),
        .buffer     (buf_a),
        .oc         (oc_a)
    );

    // Channel B
    compare_chan u_chan_b (
        .clk        (clk),
        .rst        (rst),
        .wr_en      (wr_cmpb),
        .wr_val     ({q.temp, wbyte}),
        .buffered   (buffered),
        .load_ev    (load_ev),
        .match_ev   (match_b),
        .force_ev   (force_b),
        .restart_ev (load_ev),
        .pwm        (pwm),
        .dual       (dual),
        .dir_up     (q.dir_up),
        .action     (q.act_b),
        .compare    (cmp_b),
        .buffer     (buf_b),
        .oc         (oc_b)
    );

    // Outputs straight from the state register
    assign avs_readdata    = {24'h000000, q.rdata};
    assign avs_waitrequest = q.wait_r;
    assign irq_req         = q.irq;
    assign pin_out         = q.pin_out;
    assign pin_oe          = q.pin_oe;

    // Bus handshake: one wait cycle, then one ready cycle
    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_handshake;
        @(posedge clk) disable iff (rst)
        s_req_seen |=> s_answer;
    endproperty
    a_handshake: assert property (p_handshake)
        else $error("waitrequest did not answer in one cycle");

    // Unblocked match on a tick sets the flag
    property p_match_flag;
        @(posedge clk) disable iff (rst)
        timer_tick && !q.block && q.count == cmp_a |=> q.flags[0];
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("match flag A not set after match");

    // Request follows flag and enable
    property p_irq;
        @(posedge clk) disable iff (rst)
        irq_req == (q.flags & q.ien);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request disagrees with flag and enable");

    // Blocked tick raises no match flag
    property p_block;
        @(posedge clk) disable iff (rst)
        q.block && timer_tick && !q.flags[0] |=> !q.flags[0];
    endproperty
    a_block: assert property (p_block)
        else $error("match flag set during blocked tick");

    // Normal mode wrap sets overflow
    property p_wrap;
        @(posedge clk) disable iff (rst)
        q.mode == 4'h0 && timer_tick && !wr_cnt && q.count == `CNT_MAX
        |=> q.count == `CNT_BOTTOM && q.flags[2];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("normal mode wrap or overflow flag wrong");

    // Count write lands whole and wins over ticks
    property p_cnt_write;
        @(posedge clk) disable iff (rst)
        wr_cnt |=> q.count == {$past(q.temp), $past(wbyte)} && q.block;
    endproperty
    a_cnt_write: assert property (p_cnt_write)
        else $error("count write lost or not blocking");

    // Unbuffered compare write goes straight to the working value
    property p_direct;
        @(posedge clk) disable iff (rst)
        wr_cmpa && !buffered |=> cmp_a == {$past(q.temp), $past(wbyte)};
    endproperty
    a_direct: assert property (p_direct)
        else $error("unbuffered compare write did not land");

    // Pin source and direction
    property p_pin;
        @(posedge clk) disable iff (rst)
        1'b1 |=> pin_oe == $past(pin_direction_bit) && pin_out[0] ==
                 ($past(q.act_a) != 2'h0 ? $past(oc_a) : $past(port_out_value[0]));
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin A source or direction wrong");
endmodule

// ==== tb/cpu_port_model.sv ====
// Partner model: CPU port registers and interrupt service.
// Assumes bench controls arrive on clk; acks are one-cycle pulses.
`timescale 1ns/1ps
module cpu_port_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Bench controls
    input  wire logic       service_en,
    input  wire logic [1:0] dir_set,
    input  wire logic [1:0] val_set,
    // Device side
    input  wire logic [2:0] irq_req,
    output logic      [1:0] port_out_value,
    output logic      [1:0] pin_direction_bit,
    output logic      [2:0] irq_ack
);
    // Port registers and lowest-first service
    always_ff @(posedge clk) begin
        if (rst) begin
            port_out_value    <= 2'h0;
            pin_direction_bit <= 2'h0;
            irq_ack           <= 3'h0;
        end else begin
            port_out_value    <= val_set;
            pin_direction_bit <= dir_set; // Bench raises it after output setup
            // Gap after each ack, so a cleared flag is not acked twice
            irq_ack <= (service_en && irq_ack == 3'h0) ? (irq_req & (~irq_req + 3'h1)) : 3'h0;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the two-channel compare timer.
// Assumes the one-cycle waitrequest answer and registered flags.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module testbench;
    logic        clk, rst, avs_read, avs_write, timer_tick, waitrequest;
    logic        service_en;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0]  dir_set, val_set, port_out_value, pin_direction_bit, pin_out, pin_oe;
    logic [2:0]  irq_req, irq_ack;
    logic [7:0]  rd;
    int          failures, checks;
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    cpu_port_model partner (.clk(clk), .rst(rst), .service_en(service_en), .dir_set(dir_set),
        .val_set(val_set), .irq_req(irq_req), .port_out_value(port_out_value),
        .pin_direction_bit(pin_direction_bit), .irq_ack(irq_ack));
    timer16_output_compare DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(waitrequest),
        .timer_tick(timer_tick), .irq_req(irq_req), .irq_ack(irq_ack),
        .port_out_value(port_out_value), .pin_direction_bit(pin_direction_bit),
        .pin_out(pin_out), .pin_oe(pin_oe));
    // Compare one byte and count
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle; held until waitrequest is seen low
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) chk(8'h01, 8'h00);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // One idle edge, so the next call never reassigns a strobe in this step
        @(posedge clk);
    endtask
    // Timer ticks on n consecutive edges
    task ticks(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clk);
        timer_tick <= 1'b0;
        @(posedge clk);
    endtask
    // Reset state of compare and flags
    task t_reset;
        bus(0, `OFS_CMPA_LOW, 8'h00);  chk(rd, 8'h00);
        bus(0, `OFS_FLAGS, 8'h00);     chk(rd, 8'h00);
        chk({6'h0, pin_out}, 8'h00);
    endtask
    // Compare value, blocking, match flag, toggle on pin
    task t_match;
        bus(1, `OFS_CTRL, 8'h10);
        bus(1, `OFS_IRQ_EN, 8'h01);
        bus(1, `OFS_CMPA_HIGH, 8'h12);
        bus(1, `OFS_CMPA_LOW, 8'h34);
        bus(0, `OFS_CMPA_HIGH, 8'h00); chk(rd, 8'h12);
        bus(0, `OFS_CMPA_LOW, 8'h00);  chk(rd, 8'h34);
        dir_set <= 2'h1; // Output only after setup
        bus(1, `OFS_COUNT_HIGH, 8'h12);
        bus(1, `OFS_COUNT_LOW, 8'h34); // Mode 0 only, never at a variable top
        ticks(1);
        bus(0, `OFS_FLAGS, 8'h00);     chk(rd, 8'h00);
        bus(1, `OFS_COUNT_LOW, 8'h33); // Latch still holds the high byte
        ticks(2);
        bus(0, `OFS_FLAGS, 8'h00);     chk(rd, 8'h01);
        chk({7'h0, irq_req[0]}, 8'h01);
        chk({6'h0, pin_out}, 8'h01);
        chk({6'h0, pin_oe}, 8'h01);
        bus(1, `OFS_FLAGS, 8'h01);
        bus(0, `OFS_FLAGS, 8'h00);     chk(rd, 8'h00);
    endtask
    // Force strobe, mode change, action zero
    task t_force;
        bus(1, `OFS_CTRL, 8'h14);      // Output still high from the match
        bus(0, `OFS_FLAGS, 8'h00);
        chk({6'h0, pin_out}, 8'h01);
        bus(1, `OFS_FORCE, 8'h01);
        bus(0, `OFS_FLAGS, 8'h00);     chk(rd, 8'h00);
        chk({6'h0, pin_out}, 8'h00);
        val_set <= 2'h1;
        bus(1, `OFS_CTRL, 8'h00);
        bus(0, `OFS_FLAGS, 8'h00);
        chk({6'h0, pin_out}, 8'h01);
    endtask
    // Wrap from the top count and overflow service
    task t_overflow;
        bus(1, `OFS_IRQ_EN, 8'h04);
        bus(1, `OFS_COUNT_HIGH, 8'hFF);
        bus(1, `OFS_COUNT_LOW, 8'hFF);
        ticks(1);
        bus(0, `OFS_COUNT_LOW, 8'h00);  chk(rd, 8'h00);
        bus(0, `OFS_COUNT_HIGH, 8'h00); chk(rd, 8'h00);
        bus(0, `OFS_FLAGS, 8'h00);      chk(rd, 8'h04);
        service_en <= 1'b1;
        repeat (6) @(posedge clk);
        bus(0, `OFS_FLAGS, 8'h00);      chk(rd, 8'h00);
    endtask
    // Fast PWM: reads show the buffer, matches still use the old zero
    task t_pwm;
        bus(1, `OFS_CTRL, 8'h05);
        bus(1, `OFS_CMPB_HIGH, 8'h00);
        bus(1, `OFS_CMPB_LOW, 8'h40);
        bus(0, `OFS_CMPB_LOW, 8'h00);   chk(rd, 8'h40);
        ticks(1);
        bus(0, `OFS_FLAGS, 8'h00);      chk(rd, 8'h02);
    endtask
    // Verdict and end of run
    task print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        {avs_read, avs_write, timer_tick, service_en} = 4'h0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        {dir_set, val_set} = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_match();
        t_force();
        t_overflow();
        t_pwm();
        print_verdict();
    end
endmodule
